// file: rtl/dd_device.sv
// Converter device end: frame capture, register loading, update and clear
//
// How it works
// - 24-bit frames shift in MSB first
// - Frame: read bit, select, address, 16 data
// - Frame select falling starts a write cycle
// - Exactly 24 falling clocks, else frame invalid
// - Frame select rising loads addressed register
// - Load strobe low, frame high, updates all
// - Overflow bits leave on serial data out
// - Output changes on rising, sampled falling
// - Chain of N needs 24 times N clocks; device accepts only 24 per frame
// - Frame select rising latches, stops shifting
// - Read bit selects register, data ignored
// - Next frame returns selected register contents
// - Disabled output enabled during read frame
// - Channel A read: 0x800000 then 0x180000
// - Strobe low while shifting: individual update
// - Strobe high: update on strobe falling
// - Clear forces zero or midscale code
// - Host holds clear for minimum width
// - Clear low refuses updates; value held
// - Clear command acts like clear pin
// - Reset zeroes all converter registers
// - Host sends exact clock count per frame
// - DAC writes to powered-down channel ignored; range writes still land
//
// The register offsets and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "dd_regs.svh"
module dd_device
   import dd_pkg::*;
(
   // Clock and reset
   input wire logic mclk_in,
   input wire logic rstn_in,
   // Serial link
   dd_link_if.dev link,
   // Converter side
   output logic [15:0] dac_a_out,
   output logic [15:0] dac_b_out,
   output logic [5:0] range_out,
   output logic [1:0] power_out
);

   // ************************
   // Pin sampling and edges
   // ************************
   logic [4:0] pin_s;
   logic [4:0] pin_p_q;
   logic fs_n;
   logic sclk_fall;
   logic sclk_rise;
   logic fs_fall;
   logic fs_rise;
   logic load_strobe_n_fall;
   logic clr_n;
   logic load_strobe_n_n;
   logic sdi;

   dd_sync #(.W(5)) u_sync
   (
      .clk_in(mclk_in),
      .rstn_in(rstn_in),
      .d_in({link.frame_sel_n, link.serial_clk, link.serial_data_in,
             link.load_strobe_n, link.clear_n}),
      .q_out(pin_s)
   );

   always_ff @(posedge mclk_in or negedge rstn_in)
   begin
      if (!rstn_in)
         pin_p_q <= 5'h1f;
      else
         pin_p_q <= pin_s;
   end

   assign fs_n = pin_s[4];
   assign sdi = pin_s[2];
   assign load_strobe_n_n = pin_s[1];
   assign clr_n = pin_s[0];
   assign fs_fall = pin_p_q[4] & ~pin_s[4];
   assign fs_rise = ~pin_p_q[4] & pin_s[4];
   assign sclk_fall = pin_p_q[3] & ~pin_s[3];
   assign sclk_rise = ~pin_p_q[3] & pin_s[3];
   assign load_strobe_n_fall = pin_p_q[1] & ~pin_s[1];

   // ************************
   // Shift register and bit count
   // ************************
   logic [23:0] sr_q;
   logic [`DD_CNT_W-1:0] cnt_q;
   logic rd_pend_q;
   logic rd_act_q;
   logic [5:0] rd_sel_q;
   logic [15:0] rd_data;
   dd_frame_t fr;
   logic fr_ok;

   always_ff @(posedge mclk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         sr_q <= 24'h000000;
         cnt_q <= '0;
      end
      else if (fs_fall)
      begin
         cnt_q <= '0;
         if (rd_pend_q)
            sr_q <= {8'h00, rd_data};
      end
      else if (!fs_n && sclk_fall)
      begin
         sr_q <= {sr_q[22:0], sdi};
         // Saturates so any count above 24 stays invalid
         if (cnt_q != `DD_CNT_OVER)
            cnt_q <= cnt_q + 1'b1;
      end
   end

   // Shifting only happens with frame select low
   assign fr = dd_frame_t'(sr_q);
   assign fr_ok = fs_rise &&
                  (cnt_q == `DD_CNT_W'(`DD_FRAME_BITS));

   // ************************
   // Serial data out
   // ************************
   logic sdo_q;
   logic sdo_oe_q;
   logic [2:0] cfg_q;

   always_ff @(posedge mclk_in or negedge rstn_in)
   begin
      if (!rstn_in)
         sdo_q <= 1'b0;
      else if (fs_fall)
         sdo_q <= rd_pend_q ? 1'b0 : sr_q[`DD_MSB];
      else if (!fs_n && sclk_rise)
         sdo_q <= sr_q[`DD_MSB];
   end

   always_ff @(posedge mclk_in or negedge rstn_in)
   begin
      if (!rstn_in)
         sdo_oe_q <= 1'b1;
      else
         sdo_oe_q <= ~cfg_q[`DD_CFG_SDO_DIS] | rd_act_q | rd_pend_q;
   end

   assign link.serial_data_out = sdo_q;
   assign link.sdo_oe = sdo_oe_q;

   // ************************
   // Readback
   // ************************
   logic [15:0] inp_q [2];
   logic [15:0] dac_q [2];
   logic [2:0] range_q [2];
   logic [1:0] pwr_q;

   function automatic logic ch_hit(input logic [2:0] addr, input int ch);
      ch_hit = (addr == `DD_CH_ALL) ||
               (addr == (ch == 0 ? `DD_CH_A : `DD_CH_B));
   endfunction

   function automatic int ch_idx(input logic [2:0] addr);
      ch_idx = (addr == `DD_CH_B) ? 1 : 0;
   endfunction

   always_ff @(posedge mclk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         rd_pend_q <= 1'b0;
         rd_sel_q <= 6'h00;
      end
      else if (fr_ok && fr.rd)
      begin
         rd_pend_q <= 1'b1;
         rd_sel_q <= {fr.sel, fr.addr};
      end
      else if (fs_fall)
         rd_pend_q <= 1'b0;
   end

   // Output stays enabled through the whole read frame
   always_ff @(posedge mclk_in or negedge rstn_in)
   begin
      if (!rstn_in)
         rd_act_q <= 1'b0;
      else if (fs_fall)
         rd_act_q <= rd_pend_q;
      else if (fs_rise)
         rd_act_q <= 1'b0;
   end

   always_comb
   begin
      rd_data = 16'h0000;
      case (rd_sel_q[5:3])
         `DD_SEL_DAC: rd_data = dac_q[ch_idx(rd_sel_q[2:0])];
         `DD_SEL_RANGE: rd_data = {13'h0000, range_q[ch_idx(rd_sel_q[2:0])]};
         `DD_SEL_PWR: rd_data = {14'h0000, pwr_q};
         `DD_SEL_CTL: rd_data = {13'h0000, cfg_q};
         default: rd_data = 16'h0000;
      endcase
   end

   // ************************
   // Configuration registers
   // ************************
   logic wr_ok;
   logic clr_cmd;
   logic load_cmd;

   assign wr_ok = fr_ok && !fr.rd;
   assign clr_cmd = wr_ok && fr.sel == `DD_SEL_CTL &&
                    fr.addr == `DD_CTL_CLEAR;
   assign load_cmd = wr_ok && fr.sel == `DD_SEL_CTL &&
                     fr.addr == `DD_CTL_LOAD;

   always_ff @(posedge mclk_in or negedge rstn_in)
   begin
      if (!rstn_in)
         cfg_q <= 3'h0;
      else if (wr_ok && fr.sel == `DD_SEL_CTL && fr.addr == `DD_CTL_CFG)
         cfg_q <= fr.data[2:0];
   end

   // All channels start powered down
   always_ff @(posedge mclk_in or negedge rstn_in)
   begin
      if (!rstn_in)
         pwr_q <= 2'b00;
      else if (wr_ok && fr.sel == `DD_SEL_PWR)
         pwr_q <= fr.data[1:0];
   end

   always_ff @(posedge mclk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         range_q[0] <= 3'h0;
         range_q[1] <= 3'h0;
      end
      else if (wr_ok && fr.sel == `DD_SEL_RANGE)
      begin
         for (int c = 0; c < 2; c++)
            if (ch_hit(fr.addr, c))
               range_q[c] <= fr.data[2:0];
      end
   end

   // ************************
   // Input and converter registers
   // ************************
   logic [15:0] clr_code;

   assign clr_code = cfg_q[`DD_CFG_CLR_SEL] ? `DD_MID_CODE : `DD_ZERO_CODE;

   always_ff @(posedge mclk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         inp_q[0] <= `DD_ZERO_CODE;
         inp_q[1] <= `DD_ZERO_CODE;
      end
      else if (wr_ok && fr.sel == `DD_SEL_DAC)
      begin
         for (int c = 0; c < 2; c++)
            if (ch_hit(fr.addr, c) && pwr_q[c])
               inp_q[c] <= fr.data;
      end
   end

   // Clear has priority and holds for as long as the pin is low
   always_ff @(posedge mclk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         dac_q[0] <= `DD_ZERO_CODE;
         dac_q[1] <= `DD_ZERO_CODE;
      end
      else if (!clr_n || clr_cmd)
      begin
         dac_q[0] <= clr_code;
         dac_q[1] <= clr_code;
      end
      else if ((load_strobe_n_fall && fs_n) || load_cmd)
      begin
         dac_q[0] <= inp_q[0];
         dac_q[1] <= inp_q[1];
      end
      else if (wr_ok && fr.sel == `DD_SEL_DAC && !load_strobe_n_n)
      begin
         for (int c = 0; c < 2; c++)
            if (ch_hit(fr.addr, c) && pwr_q[c])
               dac_q[c] <= fr.data;
      end
   end

   assign dac_a_out = dac_q[0];
   assign dac_b_out = dac_q[1];
   assign range_out = {range_q[1], range_q[0]};
   assign power_out = pwr_q;
endmodule
`default_nettype wire

// file: rtl/dd_regs.svh
// Offsets, field positions, codes and timing counts of the dual converter link
`ifndef DD_REGS_SVH
`define DD_REGS_SVH

// ************************
// Frame layout
// ************************
`define DD_FRAME_BITS 24
`define DD_CNT_W 5
`define DD_CNT_OVER 5'd25
`define DD_MSB 23

// ************************
// Register select codes
// ************************
`define DD_SEL_DAC 3'h0
`define DD_SEL_RANGE 3'h1
`define DD_SEL_PWR 3'h2
`define DD_SEL_CTL 3'h3

// ************************
// Channel address codes
// ************************
`define DD_CH_A 3'h0
`define DD_CH_B 3'h2
`define DD_CH_ALL 3'h4

// ************************
// Control register functions and bits
// ************************
`define DD_CTL_NOP 3'h0
`define DD_CTL_CFG 3'h1
`define DD_CTL_CLEAR 3'h4
`define DD_CTL_LOAD 3'h5
`define DD_CFG_SDO_DIS 0
`define DD_CFG_CLR_SEL 2

// ************************
// Reset and clear codes
// ************************
`define DD_ZERO_CODE 16'h0000
`define DD_MID_CODE 16'h8000

// ************************
// Host register map
// ************************
`define DD_H_TX 4'h0
`define DD_H_CTRL 4'h4
`define DD_H_RX 4'h8
`define DD_H_GO 0
`define DD_H_LOAD_STROBE_N 1
`define DD_H_CLR 2
`define DD_H_BUSY 0

// ************************
// Timing
// ************************
`define DD_CLK_NS 8
`define DD_SCLK_HALF_NS 64
`define DD_SCLK_HALF_CYC (`DD_SCLK_HALF_NS / `DD_CLK_NS)
`define DD_CLR_PW_NS 20
`define DD_CLR_PW_CYC ((`DD_CLR_PW_NS + `DD_CLK_NS - 1) / `DD_CLK_NS)

`endif

// file: rtl/dd_pkg.sv
// Types shared by both ends of the dual converter link
package dd_pkg;

   typedef struct packed
   {
      logic rd;
      logic rsv;
      logic [2:0] sel;
      logic [2:0] addr;
      logic [15:0] data;
   } dd_frame_t;

   typedef enum logic [3:0]
   {
      HS_IDLE = 4'b0001,
      HS_HI = 4'b0010,
      HS_LO = 4'b0100,
      HS_END = 4'b1000
   } dd_hstate_t;

endpackage

// file: rtl/dd_link_if.sv
// Serial link between host controller and converter device
`timescale 1ns/1ps
`default_nettype none
interface dd_link_if;
   logic frame_sel_n;
   logic serial_clk;
   logic serial_data_in;
   logic serial_data_out;
   logic sdo_oe;
   logic load_strobe_n;
   logic clear_n;
   logic sdo_line;

   // Released line reads high, as with a pull-up
   assign sdo_line = sdo_oe ? serial_data_out : 1'b1;

   modport dev
   (
      input frame_sel_n,
      input serial_clk,
      input serial_data_in,
      input load_strobe_n,
      input clear_n,
      output serial_data_out,
      output sdo_oe
   );

   modport host
   (
      output frame_sel_n,
      output serial_clk,
      output serial_data_in,
      output load_strobe_n,
      output clear_n,
      input sdo_line
   );
endinterface
`default_nettype wire

// file: rtl/dd_sync.sv
// Two-stage synchroniser for pins from outside the clock domain
`timescale 1ns/1ps
`default_nettype none
module dd_sync
#(
   parameter int W = 1
)
(
   // Clock and reset
   input wire logic clk_in,
   input wire logic rstn_in,
   // Data
   input wire logic [W-1:0] d_in,
   output logic [W-1:0] q_out
);
   logic [W-1:0] meta_q;
   logic [W-1:0] sync_q;

   always_ff @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         meta_q <= '1;
         sync_q <= '1;
      end
      else
      begin
         meta_q <= d_in;
         sync_q <= meta_q;
      end
   end

   assign q_out = sync_q;
endmodule
`default_nettype wire

// file: rtl/dd_host.sv
// Host controller end: register port driving frames onto the serial link
`timescale 1ns/1ps
`default_nettype none
`include "dd_regs.svh"
module dd_host
   import dd_pkg::*;
#(
   parameter int CHAIN = 1,
   parameter int HALF = `DD_SCLK_HALF_CYC,
   parameter int CLR_PW = `DD_CLR_PW_CYC
)
(
   // Clock and reset
   input wire logic mclk_in,
   input wire logic rstn_in,
   // Register port
   input wire logic [3:0] addr_in,
   input wire logic [31:0] wr_data_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [31:0] rd_data_out,
   // Serial link
   dd_link_if.host link
);
   localparam int NB = `DD_FRAME_BITS * CHAIN;

   dd_hstate_t state_q;
   logic [NB-1:0] tx_q;
   logic [NB-1:0] rx_q;
   logic [15:0] div_q;
   logic [15:0] bit_q;
   logic [15:0] clr_cnt_q;
   logic fs_q;
   logic sclk_q;
   logic sdi_q;
   logic load_strobe_n_q;
   logic clr_q;
   logic sdo_s;
   logic tick;
   logic busy;

   dd_sync #(.W(1)) u_sync
   (
      .clk_in(mclk_in),
      .rstn_in(rstn_in),
      .d_in(link.sdo_line),
      .q_out(sdo_s)
   );

   assign tick = (div_q == 16'(HALF - 1));
   assign busy = (state_q != HS_IDLE);

   // ************************
   // Frame engine
   // ************************
   always_ff @(posedge mclk_in or negedge rstn_in)
   begin
      if (!rstn_in)
         div_q <= 16'h0000;
      else if (state_q == HS_IDLE || tick)
         div_q <= 16'h0000;
      else
         div_q <= div_q + 16'h0001;
   end

   always_ff @(posedge mclk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         state_q <= HS_IDLE;
         fs_q <= 1'b1;
         sclk_q <= 1'b1;
         sdi_q <= 1'b0;
         bit_q <= 16'h0000;
         tx_q <= '0;
         rx_q <= '0;
      end
      else
      begin
         case (state_q)
            HS_IDLE:
            begin
               if (wr_in && addr_in == `DD_H_TX)
                  tx_q <= (tx_q << `DD_FRAME_BITS) | NB'(wr_data_in[23:0]);
               if (wr_in && addr_in == `DD_H_CTRL && wr_data_in[`DD_H_GO])
               begin
                  fs_q <= 1'b0;
                  sdi_q <= tx_q[NB-1];
                  bit_q <= 16'h0000;
                  state_q <= HS_HI;
               end
            end
            HS_HI:
               if (tick)
               begin
                  sclk_q <= 1'b0;
                  rx_q <= {rx_q[NB-2:0], sdo_s};
                  tx_q <= tx_q << 1;
                  bit_q <= bit_q + 16'h0001;
                  state_q <= HS_LO;
               end
            HS_LO:
               if (tick)
               begin
                  sclk_q <= 1'b1;
                  sdi_q <= tx_q[NB-1];
                  // Exactly 24 per device in the chain
                  state_q <= (bit_q == 16'(NB)) ? HS_END : HS_HI;
               end
            HS_END:
               if (tick)
               begin
                  fs_q <= 1'b1;
                  state_q <= HS_IDLE;
               end
            default:
               state_q <= HS_IDLE;
         endcase
      end
   end

   // ************************
   // Load strobe and clear pulse
   // ************************
   always_ff @(posedge mclk_in or negedge rstn_in)
   begin
      if (!rstn_in)
         load_strobe_n_q <= 1'b1;
      else if (wr_in && addr_in == `DD_H_CTRL)
         load_strobe_n_q <= wr_data_in[`DD_H_LOAD_STROBE_N];
   end

   // Pulse is stretched to the minimum clear width
   always_ff @(posedge mclk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         clr_q <= 1'b1;
         clr_cnt_q <= 16'h0000;
      end
      else if (wr_in && addr_in == `DD_H_CTRL && wr_data_in[`DD_H_CLR])
      begin
         clr_q <= 1'b0;
         clr_cnt_q <= 16'(CLR_PW);
      end
      else if (clr_cnt_q != 16'h0000)
         clr_cnt_q <= clr_cnt_q - 16'h0001;
      else
         clr_q <= 1'b1;
   end

   // ************************
   // Read port
   // ************************
   always_ff @(posedge mclk_in or negedge rstn_in)
   begin
      if (!rstn_in)
         rd_data_out <= 32'h00000000;
      else if (rd_in)
      begin
         case (addr_in)
            `DD_H_CTRL: rd_data_out <= {29'h00000000, ~clr_q, load_strobe_n_q, busy};
            `DD_H_RX: rd_data_out <= {8'h00, rx_q[23:0]};
            default: rd_data_out <= 32'h00000000;
         endcase
      end
      else
         rd_data_out <= 32'h00000000;
   end

   assign link.frame_sel_n = fs_q;
   assign link.serial_clk = sclk_q;
   assign link.serial_data_in = sdi_q;
   assign link.load_strobe_n = load_strobe_n_q;
   assign link.clear_n = clr_q;
endmodule
`default_nettype wire

// file: sim/dd_link_sva.sv
// Concurrent checks on the serial link between host and device ends
`timescale 1ns/1ps
`default_nettype none
module dd_link_sva
(
   // Clock and reset
   input wire logic mclk_in,
   input wire logic rstn_in,
   // Serial link
   input wire logic frame_sel_n,
   input wire logic serial_clk,
   input wire logic serial_data_in,
   input wire logic serial_data_out,
   input wire logic clear_n
);
   logic sclk_q;
   logic [5:0] falls_q;

   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (!rstn_in);

   // Falling clock edges counted inside the current frame
   always_ff @(posedge mclk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         sclk_q <= 1'b1;
         falls_q <= 6'h00;
      end
      else
      begin
         sclk_q <= serial_clk;
         if (frame_sel_n)
            falls_q <= 6'h00;
         else if (sclk_q && !serial_clk)
            falls_q <= falls_q + 6'h01;
      end
   end

   // ************************
   // Assertions
   // ************************
   idle_clk_a: assert property (frame_sel_n |-> serial_clk)
      else $error("serial clock low outside a frame");
   first_fall_a: assert property ($fell(frame_sel_n) |->
      serial_clk[*7] ##[1:3] !serial_clk)
      else $error("first clock fall not one half period after start");
   frame_count_a: assert property ($rose(frame_sel_n) |->
      falls_q == 6'h18)
      else $error("frame closed without 24 clock falls");
   data_hold_a: assert property (!serial_clk && !sclk_q |->
      $stable(serial_data_in))
      else $error("host data moved while clock low");
   sdo_hold_a: assert property (!frame_sel_n && !serial_clk && !sclk_q
      |-> $stable(serial_data_out))
      else $error("device data moved while clock low");
   low_half_a: assert property ($fell(serial_clk) |->
      !serial_clk[*8] ##1 serial_clk)
      else $error("clock low phase not 8 cycles");
   clear_width_a: assert property ($fell(clear_n) |->
      !clear_n[*4] ##1 clear_n)
      else $error("clear pulse not 4 cycles");
   idle_sdo_a: assert property (frame_sel_n[*8] |->
      $stable(serial_data_out))
      else $error("device output moved between frames");

   cover property ($rose(frame_sel_n));
   cover property ($fell(clear_n));
   cover property (frame_sel_n[*8] ##1 !frame_sel_n);
endmodule
`default_nettype wire

// file: sim/testbench.sv
// Testbench joining host and device ends over the serial link
`timescale 1ns/1ps
`default_nettype none
`include "dd_regs.svh"
module testbench
   import dd_pkg::*;
;
   logic mclk_in;
   logic rstn_in;
   logic [3:0] addr;
   logic [31:0] wr_data;
   logic [31:0] rd_data;
   logic wr;
   logic rd;
   logic [15:0] dac_a;
   logic [15:0] dac_b;
   logic [15:0] dac_a2;
   logic [1:0] power;
   logic [1:0] power2;
   logic [5:0] rng;
   int num_errors;
   int checks;

   dd_link_if lk ();
   // Second link driven by the bench to break the frame length
   dd_link_if lk2 ();

   dd_host dd_host_inst (.mclk_in(mclk_in), .rstn_in(rstn_in),
      .addr_in(addr), .wr_data_in(wr_data), .wr_in(wr), .rd_in(rd),
      .rd_data_out(rd_data), .link(lk));
   dd_device dd_device_inst (.mclk_in(mclk_in), .rstn_in(rstn_in),
      .link(lk), .dac_a_out(dac_a), .dac_b_out(dac_b), .range_out(rng),
      .power_out(power));
   dd_device dd_device_inst2 (.mclk_in(mclk_in), .rstn_in(rstn_in),
      .link(lk2), .dac_a_out(dac_a2), .dac_b_out(), .range_out(),
      .power_out(power2));
   dd_link_sva dd_link_sva_inst (.mclk_in(mclk_in), .rstn_in(rstn_in),
      .frame_sel_n(lk.frame_sel_n), .serial_clk(lk.serial_clk),
      .serial_data_in(lk.serial_data_in),
      .serial_data_out(lk.serial_data_out), .clear_n(lk.clear_n));

   initial
   begin
      mclk_in = 1'b0;
      forever #4 mclk_in = ~mclk_in;
   end

   // ************************
   // Tasks
   // ************************
   task end_of_test();
      if (num_errors == 0 && checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   task chk(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp)
      begin
         num_errors++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task wr_reg(input logic [3:0] a, input logic [31:0] d);
      @(posedge mclk_in);
      addr <= a;
      wr_data <= d;
      wr <= 1'b1;
      @(posedge mclk_in);
      wr <= 1'b0;
   endtask

   task rd_reg(input logic [3:0] a, output logic [31:0] d);
      @(posedge mclk_in);
      addr <= a;
      rd <= 1'b1;
      @(posedge mclk_in);
      rd <= 1'b0;
      #1;
      d = rd_data;
   endtask

   // One host frame, then wait until busy drops and the device settles
   task send(input logic [23:0] f, input logic [31:0] ctl);
      logic [31:0] v;
      wr_reg(`DD_H_TX, {8'h00, f});
      wr_reg(`DD_H_CTRL, ctl);
      repeat (4) @(posedge mclk_in);
      v = 32'h1;
      for (int i = 0; i < 400 && v[0] !== 1'b0; i++)
         rd_reg(`DD_H_CTRL, v);
      chk(v[15:0] & 16'h0001, 16'h0000);
      repeat (12) @(posedge mclk_in);
   endtask

   // Frame of n bits on the second link, MSB first, 125 ns link clock
   // Link clock is unrelated to mclk, so its edges drift across cycles
   task bits2(input int n, input logic [31:0] f);
      @(posedge mclk_in);
      lk2.frame_sel_n <= 1'b0;
      lk2.serial_data_in <= f[n-1];
      for (int i = n - 1; i >= 0; i--)
      begin
         #62.5;
         lk2.serial_clk <= 1'b0;
         #62.5;
         lk2.serial_clk <= 1'b1;
         if (i > 0)
            lk2.serial_data_in <= f[i-1];
      end
      #62.5;
      lk2.frame_sel_n <= 1'b1;
      // Released line must not keep the last bit
      lk2.serial_data_in <= ~f[0];
      repeat (12) @(posedge mclk_in);
   endtask

   // ************************
   // Tests
   // ************************
   initial
   begin
      repeat (50000) @(posedge mclk_in);
      $display("ERROR %0t: watchdog expired", $time);
      num_errors++;
      end_of_test();
   end

   initial
   begin
      logic [31:0] v;
      rstn_in = 1'b0;
      addr = 4'h0;
      wr_data = 32'h0;
      wr = 1'b0;
      rd = 1'b0;
      lk2.frame_sel_n = 1'b1;
      lk2.serial_clk = 1'b1;
      lk2.serial_data_in = 1'b0;
      lk2.load_strobe_n = 1'b0;
      lk2.clear_n = 1'b1;
      num_errors = 0;
      checks = 0;
      repeat (2) @(posedge mclk_in);
      rstn_in <= 1'b1;
      #1;
      chk(dac_a, 16'h0000);
      chk(dac_b, 16'h0000);
      chk({14'h0, power}, 16'h0000);
      rd_reg(4'hc, v);
      chk(v[15:0], 16'h0000);
      send(24'h001234, 32'h1);
      chk(dac_a, 16'h0000);
      send(24'h100003, 32'h1);
      chk({14'h0, power}, 16'h0003);
      send(24'h0c0004, 32'h1);
      chk({10'h0, rng}, 16'h0024);
      send(24'h001234, 32'h1);
      chk(dac_a, 16'h1234);
      send(24'h02abcd, 32'h3);
      chk(dac_b, 16'h0000);
      wr_reg(`DD_H_CTRL, 32'h0);
      repeat (12) @(posedge mclk_in);
      chk(dac_b, 16'habcd);
      for (int i = 0; i < 2; i++)
      begin
         send(i ? 24'h820000 : 24'h800000, 32'h3);
         send(24'h180000, 32'h3);
         rd_reg(`DD_H_RX, v);
         chk(v[15:0], i ? 16'habcd : 16'h1234);
      end
      wr_reg(`DD_H_CTRL, 32'h6);
      rd_reg(`DD_H_CTRL, v);
      chk(v[15:0], 16'h0006);
      repeat (12) @(posedge mclk_in);
      chk(dac_a, 16'h0000);
      chk(dac_b, 16'h0000);
      send(24'h190004, 32'h3);
      chk(dac_a, 16'h0000);
      wr_reg(`DD_H_CTRL, 32'h6);
      repeat (12) @(posedge mclk_in);
      chk(dac_b, 16'h8000);
      send(24'h001111, 32'h1);
      chk(dac_a, 16'h1111);
      send(24'h1c0000, 32'h1);
      chk(dac_a, 16'h8000);
      rd_reg(`DD_H_RX, v);
      chk(v[15:0], 16'h1111);
      chk(v[23:8], 16'h0011);
      send(24'h190001, 32'h1);
      chk({15'h0, lk.sdo_oe}, 16'h0000);
      send(24'h800000, 32'h1);
      send(24'h180000, 32'h1);
      rd_reg(`DD_H_RX, v);
      chk(v[15:0], 16'h8000);
      chk({15'h0, lk.sdo_oe}, 16'h0000);
      send(24'h1d0000, 32'h1);
      chk(dac_a, 16'h1111);
      chk(dac_b, 16'habcd);
      bits2(24, 32'h100003);
      chk({14'h0, power2}, 16'h0003);
      bits2(23, 32'h005555);
      chk(dac_a2, 16'h0000);
      bits2(25, 32'h1005555);
      chk(dac_a2, 16'h0000);
      bits2(24, 32'h005555);
      chk(dac_a2, 16'h5555);
      end_of_test();
   end
endmodule
`default_nettype wire
